// ---- src/srq_status.sv ----
// Service-request status byte, enable mask and request line.
// Assumes all strobes are one-cycle pulses from logic on sys_clk_i.
//
// Summary of operation
// - Data ready has weight 1, code error weight 2, instrument error weight 4.
// - Weight 2 is always forced into the mask, so code error can never be masked.
// - An enabled condition sets its own status bit and the request bit 6 together.
// - A set request bit drives the request line true toward the controller.
// - Status bits and request stay until serial poll, clear message or controller reset.
// - A clear message or controller reset also returns the mask to its disabled state.
// - Automatic operation leaves the pending request and status bits unchanged.
// - The polled byte has weights 1, 2, 4 and 64 and reads zero at 8, 16, 32, 128.
`timescale 1ns/1ps
module srq_status (
    // Clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                rst_n_i,
    // Service conditions, one-cycle pulses
    input  srq_status_pkg::cond_s    cond_i,
    // Special function entry
    input  wire logic                special_function_key_i,
    input  wire logic [6:0]          sf_prefix_i,
    input  wire logic [7:0]          special_function_program_code_i,
    // Clearing and mode events
    input  srq_status_pkg::clear_s   clear_i,
    input  wire logic                auto_op_i,
    // Status and request outputs
    output logic      [7:0]          status_byte_o,
    output logic      [7:0]          poll_data_o,
    output logic                     poll_valid_o,
    output logic      [2:0]          enable_mask_o,
    output logic                     srq_o
);

    // Status byte assembly, used for live view and poll data
    function automatic logic [7:0] pack_status(input logic [2:0] cond_bits,
                                               input logic       req_flag);
        logic [7:0] b;
        b = srq_status_pkg::STATUS_RESET;
        b[srq_status_pkg::DATA_READY_POS] = cond_bits[0];
        b[srq_status_pkg::CODE_ERR_POS]   = cond_bits[1];
        b[srq_status_pkg::INSTR_ERR_POS]  = cond_bits[2];
        b[srq_status_pkg::REQ_FLAG_POS]   = req_flag;
        return b;
    endfunction : pack_status

    logic [2:0] mask_q;
    logic [2:0] mask_d;
    logic       req_flag_q;
    logic       req_flag_d;
    logic       srq_q;
    logic [7:0] status_q;
    logic [7:0] poll_data_q;
    logic       poll_valid_q;
    logic [2:0] flags;

    // Decode of incoming events
    wire logic [2:0] cond_vec     = cond_i;
    wire logic       mask_load    = special_function_key_i
                                    && sf_prefix_i == srq_status_pkg::SRQ_MASK_FUNC;
    wire logic [2:0] mask_loaded  = special_function_program_code_i[2:0]
                                    | srq_status_pkg::MASK_FORCED;
    wire logic       mask_reset   = clear_i.clear_msg | clear_i.ctrl_reset;
    wire logic       req_clear    = clear_i.serial_poll | mask_reset;
    wire logic [2:0] enabled_set  = cond_vec & mask_q;
    wire logic       any_enabled  = |enabled_set;

    // Mask: clear message and controller reset take priority over a load in the same cycle
    assign mask_d = mask_reset ? srq_status_pkg::MASK_DISABLED :
                    mask_load  ? mask_loaded : mask_q;

    // Request bit: a new enabled event wins over any clear
    assign req_flag_d = any_enabled | (req_flag_q & ~req_clear);

    sticky_flag_bank #(
        .N (srq_status_pkg::COND_COUNT)
    ) u_flags (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .set_i     (enabled_set),
        .clr_i     (req_clear),
        .flags_o   (flags)
    );

    // Next flag state, same terms as the bank, so the live byte lands with it
    wire logic [2:0] flags_next = enabled_set | (flags & ~{3{req_clear}});
    wire logic [7:0] status_d   = pack_status(flags_next, req_flag_d);

    // Byte as it stands before the poll edge
    wire logic [7:0] poll_byte  = pack_status(flags, req_flag_q);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_q <= srq_status_pkg::MASK_DISABLED;
        end else begin
            mask_q <= mask_d;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_flag_q <= 1'b0;
            srq_q      <= 1'b0;
            status_q   <= srq_status_pkg::STATUS_RESET;
        end else begin
            req_flag_q <= req_flag_d;
            srq_q      <= req_flag_d;
            status_q   <= status_d;
        end
    end

    // Poll answer: byte as it stood when the poll was taken
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            poll_data_q  <= srq_status_pkg::STATUS_RESET;
            poll_valid_q <= 1'b0;
        end else begin
            poll_valid_q <= clear_i.serial_poll;
            if (clear_i.serial_poll) begin
                poll_data_q <= poll_byte;
            end
        end
    end

    assign status_byte_o = status_q;
    assign poll_data_o   = poll_data_q;
    assign poll_valid_o  = poll_valid_q;
    assign enable_mask_o = mask_q;
    assign srq_o         = srq_q;

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_mask_load_value : assert property (
        (mask_load && !mask_reset)
        |=> enable_mask_o == ($past(special_function_program_code_i[2:0]) | 3'h2))
        else $error("Mask not loaded from suffix");

    chk_code_err_forced : assert property (enable_mask_o[1])
        else $error("Code error weight missing from mask");

    chk_event_sets_both : assert property (
        (cond_i.instr_error && enable_mask_o[2])
        |=> status_byte_o[2] && status_byte_o[6])
        else $error("Enabled instrument error did not set bit and request");

    chk_code_err_request : assert property (
        cond_i.code_error |=> status_byte_o[1] && srq_o)
        else $error("Code error did not raise a request");

    chk_masked_no_set : assert property (
        (cond_i.data_ready && !enable_mask_o[0] && !status_byte_o[0])
        |=> !status_byte_o[0])
        else $error("Masked data ready set its bit");

    chk_srq_tracks_flag : assert property (srq_o == status_byte_o[6])
        else $error("Request line differs from request bit");

    chk_hold_until_clear : assert property (
        (status_byte_o[6] && clear_i == '0) |=> status_byte_o[6])
        else $error("Request dropped without a clearing event");

    chk_poll_clears_srq : assert property (
        (clear_i.serial_poll && cond_i == '0) |=> !srq_o && status_byte_o == 8'h00)
        else $error("Serial poll did not clear request");

    chk_clear_disables : assert property (
        (clear_i.clear_msg || clear_i.ctrl_reset) |=> enable_mask_o == 3'h2)
        else $error("Clear did not disable mask");

    chk_auto_op_keeps : assert property (
        (auto_op_i && clear_i == '0 && cond_i == '0)
        |=> status_byte_o == $past(status_byte_o))
        else $error("Automatic operation changed status");

    chk_zero_weights : assert property (
        (status_byte_o & 8'hb8) == 8'h00 && (poll_data_o & 8'hb8) == 8'h00)
        else $error("Unused status weights not zero");

    chk_poll_answer : assert property (
        clear_i.serial_poll |=> poll_valid_o ##1 !poll_valid_o || $past(clear_i.serial_poll))
        else $error("Poll answer strobe malformed");

    chk_poll_valid_idle : assert property (
        !clear_i.serial_poll |=> !poll_valid_o)
        else $error("Poll answer strobe without a poll");

    chk_poll_byte_value : assert property (
        clear_i.serial_poll |=> poll_data_o == $past(status_byte_o))
        else $error("Poll data differs from the status byte");

    chk_clear_drops_srq : assert property (
        (clear_i != '0 && cond_i == '0) |=> !srq_o)
        else $error("Request line stayed up after a clearing event");

    chk_srq_rises : assert property (
        ((cond_i & enable_mask_o) != 3'h0) |=> srq_o)
        else $error("Enabled event did not raise the request line");

    chk_prefix_ignored : assert property (
        (special_function_key_i && sf_prefix_i != srq_status_pkg::SRQ_MASK_FUNC
         && !mask_reset) |=> $stable(enable_mask_o))
        else $error("Other special function changed the mask");

    chk_mask_idle_stable : assert property (
        (!special_function_key_i && !mask_reset) |=> $stable(enable_mask_o))
        else $error("Mask changed without a load or clear");

    chk_clear_beats_load : assert property (
        (mask_load && mask_reset) |=> enable_mask_o == srq_status_pkg::MASK_DISABLED)
        else $error("Mask load won over a clearing event");

    chk_flag_needs_request : assert property (
        (status_byte_o[2:0] != 3'h0) == status_byte_o[6])
        else $error("Condition bits and request bit disagree");

    cov_poll_request  : cover property (status_byte_o[6] ##1 clear_i.serial_poll ##1 !srq_o);
    cov_mask_then_evt : cover property (mask_load ##[1:4] cond_i.data_ready ##1 srq_o);
    cov_set_on_clear  : cover property (clear_i.serial_poll && cond_i.code_error ##1 srq_o);
    cov_clear_msg     : cover property (clear_i.clear_msg ##1 !srq_o);
    cov_masked_event  : cover property (cond_i.data_ready && !enable_mask_o[0]);

endmodule : srq_status

// ---- src/srq_status_pkg.sv ----
// Constants and carriers of the service-request status logic.
// Assumes a single 100 MHz clock domain shared by all users.
package srq_status_pkg;

    // Number of service conditions, each with a mask bit
    localparam int unsigned COND_COUNT = 3;

    // Bit positions inside the status byte
    localparam int unsigned DATA_READY_POS = 0;
    localparam int unsigned CODE_ERR_POS   = 1;
    localparam int unsigned INSTR_ERR_POS  = 2;
    localparam int unsigned REQ_FLAG_POS   = 6;

    // Special function number that loads the enable mask
    localparam logic [6:0] SRQ_MASK_FUNC   = 7'h16;

    // Reset and cleared values
    localparam logic [7:0] STATUS_RESET    = 8'h00;
    localparam logic [2:0] FLAGS_RESET     = 3'h0;
    localparam logic [2:0] MASK_FORCED     = 3'h2;
    localparam logic [2:0] MASK_DISABLED   = 3'h2;

    // Service conditions, one bit each, weight order
    typedef struct packed {
        logic instr_error;
        logic code_error;
        logic data_ready;
    } cond_s;

    // Events that clear pending requests
    typedef struct packed {
        logic serial_poll;
        logic clear_msg;
        logic ctrl_reset;
    } clear_s;

endpackage : srq_status_pkg

// ---- src/sticky_flag_bank.sv ----
// Bank of sticky flags, set by hardware, cleared by a common strobe.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module sticky_flag_bank #(
    parameter int unsigned N = 3
) (
    // Clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    // Set and clear
    input  wire logic [N-1:0] set_i,
    input  wire logic         clr_i,
    // Flag state
    output logic      [N-1:0] flags_o
);

    logic [N-1:0] flags_q;
    logic [N-1:0] flags_d;

    // Set wins over a clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_flag
            assign flags_d[g] = set_i[g] | (flags_q[g] & ~clr_i);
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;

    chk_flag_hold_clear : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (!clr_i && set_i == '0) |=> flags_q == $past(flags_q))
        else $error("Sticky flags changed without set or clear");

endmodule : sticky_flag_bank

// ---- tb/poll_ctrl_model.sv ----
// Bus controller model that serially polls the status logic.
// Assumes the bench calls do_poll and that poll data answers one cycle later.
`timescale 1ns/1ps
module poll_ctrl_model (
    // Clock
    input  wire logic       sys_clk_i,
    // Poll answer
    input  wire logic       poll_valid_i,
    input  wire logic [7:0] poll_data_i,
    // Poll strobe
    output logic            serial_poll_o
);
    initial serial_poll_o = 1'b0;

    // One poll: strobe for a cycle, take the byte at the answer
    task automatic do_poll(output logic ok, output logic [7:0] b);
        @(negedge sys_clk_i);
        serial_poll_o = 1'b1;
        @(negedge sys_clk_i);
        serial_poll_o = 1'b0;
        ok = poll_valid_i;
        b  = poll_data_i;
    endtask : do_poll
endmodule : poll_ctrl_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the service-request status logic.
// Assumes the poll controller model drives the serial poll strobe.
`timescale 1ns/1ps
module tb_top;
    logic                  sys_clk_i = 1'b0;
    logic                  rst_n_i   = 1'b0;
    srq_status_pkg::cond_s cond_i    = '0;
    logic                  key_i     = 1'b0;
    logic [6:0]            prefix_i  = 7'h16;
    logic [7:0]            code_i    = 8'h00;
    logic [1:0]            clr_req   = 2'h0;
    logic                  auto_i    = 1'b0;
    logic                  poll_w;
    logic [7:0]            status_w, pdata_w;
    logic                  pvalid_w, srq_w, ok;
    logic [2:0]            mask_w;
    logic [7:0]            b;
    int                    mismatches = 0;
    int                    total_checks = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    srq_status u_dut (
        .sys_clk_i                       (sys_clk_i),
        .rst_n_i                         (rst_n_i),
        .cond_i                          (cond_i),
        .special_function_key_i          (key_i),
        .sf_prefix_i                     (prefix_i),
        .special_function_program_code_i (code_i),
        .clear_i                         (srq_status_pkg::clear_s'({poll_w, clr_req})),
        .auto_op_i                       (auto_i),
        .status_byte_o                   (status_w),
        .poll_data_o                     (pdata_w),
        .poll_valid_o                    (pvalid_w),
        .enable_mask_o                   (mask_w),
        .srq_o                           (srq_w)
    );

    poll_ctrl_model u_ctrl (
        .sys_clk_i     (sys_clk_i),
        .poll_valid_i  (pvalid_w),
        .poll_data_i   (pdata_w),
        .serial_poll_o (poll_w)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle pulse of the given inputs, outputs settled on return
    task automatic pulse(input logic [2:0] c, input logic k, input logic [7:0] cd,
                         input logic [1:0] clr);
        @(negedge sys_clk_i);
        cond_i  = srq_status_pkg::cond_s'(c);
        key_i   = k;
        code_i  = cd;
        clr_req = clr;
        @(negedge sys_clk_i);
        cond_i  = '0;
        key_i   = 1'b0;
        clr_req = 2'h0;
    endtask : pulse

    task automatic test_reset;
        check(status_w, 8'h00);
        check({5'h00, mask_w}, 8'h02);
        check({7'h00, srq_w}, 8'h00);
        check({7'h00, pvalid_w}, 8'h00);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_mask;
        for (int s = 0; s < 8; s++) begin
            pulse(3'h0, 1'b1, {5'h1f, 3'(s)}, 2'h0);
            check({5'h00, mask_w}, {5'h00, 3'(s) | 3'h2});
        end
        prefix_i = 7'h15;
        pulse(3'h0, 1'b1, 8'h00, 2'h0);
        check({5'h00, mask_w}, 8'h07);
        prefix_i = 7'h16;
        $display("test_mask done");
    endtask : test_mask

    task automatic test_event_poll;
        pulse(3'h0, 1'b1, 8'h01, 2'h0);
        pulse(3'h1, 1'b0, 8'h00, 2'h0);
        check(status_w, 8'h41);
        check({7'h00, srq_w}, 8'h01);
        pulse(3'h4, 1'b0, 8'h00, 2'h0);
        check(status_w, 8'h41);
        @(negedge sys_clk_i);
        auto_i = 1'b1;
        @(negedge sys_clk_i);
        auto_i = 1'b0;
        check(status_w, 8'h41);
        u_ctrl.do_poll(ok, b);
        check({7'h00, ok}, 8'h01);
        check(b, 8'h41);
        check({srq_w, status_w[6:0]}, 8'h00);
        $display("test_event_poll done");
    endtask : test_event_poll

    task automatic test_clear;
        for (int i = 0; i < 2; i++) begin
            pulse(3'h0, 1'b1, 8'h05, 2'h0);
            pulse(3'h6, 1'b0, 8'h00, 2'h0);
            check(status_w, 8'h46);
            pulse(3'h0, 1'b0, 8'h00, (i == 0) ? 2'h2 : 2'h1);
            check({srq_w, status_w[6:0]}, 8'h00);
            check({5'h00, mask_w}, 8'h02);
            pulse(3'h7, 1'b0, 8'h00, 2'h0);
            check(status_w, 8'h42);
            u_ctrl.do_poll(ok, b);
            check({7'h00, ok}, 8'h01);
            check(b, 8'h42);
        end
        pulse(3'h0, 1'b1, 8'h05, 2'h2);
        check({5'h00, mask_w}, 8'h02);
        $display("test_clear done");
    endtask : test_clear

    task automatic test_mid_reset;
        pulse(3'h0, 1'b1, 8'h05, 2'h0);
        pulse(3'h5, 1'b0, 8'h00, 2'h0);
        check(status_w, 8'h45);
        @(negedge sys_clk_i);
        rst_n_i = 1'b0;
        @(negedge sys_clk_i);
        check(status_w, 8'h00);
        check(pdata_w, 8'h00);
        check({5'h00, mask_w}, 8'h02);
        check({7'h00, srq_w}, 8'h00);
        @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        pulse(3'h1, 1'b0, 8'h00, 2'h0);
        check(status_w, 8'h00);
        pulse(3'h2, 1'b0, 8'h00, 2'h0);
        check({srq_w, status_w[6:0]}, 8'hc2);
        $display("test_mid_reset done");
    endtask : test_mid_reset

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (2) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        test_reset();
        test_mask();
        test_event_poll();
        test_clear();
        test_mid_reset();
        tally_and_finish();
    end
endmodule : tb_top
